// [hdl/acs_capture.v]
/*
 ADC capture sequencer: frequency count, sample into memory, upload to the
 USB side, optional forwarding to the test-equipment outputs, status lamps.
 Assumes an APB master on pclk, a converter clock well below pclk/4 that is
 oversampled here, and external DDR SRAM answering reads one edge later.
*/
// How it works
// - Capture data at converter clock edges
// - Samples pass a FIFO before memory
// - FIFO output goes internal or external memory
// - Upload starts only after count stored
// - Forward samples to analyzer and probe outputs
// - Count converter clock edges, report to host
// - Phases run count, sample, upload in order
// - Frequency result readable after count phase
// - Upload lamp lit during frequency count
// - Sample lamp lit for whole collection
// - Upload lamp lit throughout upload
// - Memory holds 65536 samples of 16 bits
// - Idle lamp lit when nothing runs
// - Activity lamp toggles with converter clock
// - One lock lamp per clock manager
// - 36 input lines, low 16 captured, both edges
`timescale 1ns/1ps
`include "acs_regs.vh"
module acs_capture #(
   parameter ADDR_W = 16,
   parameter SAMPLE_W = 16,
   parameter BUS_W = 36,
   parameter FIFO_AW = 2,
   parameter ACT_DIV_W = 20,
   parameter GATE_CYC = `ACS_GATE_MS * `ACS_CLK_KHZ
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire conv_clk,
   input wire [BUS_W-1:0] conv_data,
   output reg ext_wr_en,
   output reg ext_rd_en,
   output reg [ADDR_W-1:0] ext_addr,
   output reg [SAMPLE_W-1:0] ext_wdata,
   input wire [SAMPLE_W-1:0] ext_rdata,
   output reg [SAMPLE_W-1:0] usb_data,
   output reg usb_valid,
   input wire usb_ready,
   output reg [SAMPLE_W-1:0] la_data,
   output reg [SAMPLE_W-1:0] probe_data,
   output reg probe_valid,
   input wire [4:0] clock_manager_locked,
   output wire upload_indicator,
   output wire sample_indicator,
   output wire idle_indicator,
   output wire conv_clock_activity_indicator,
   output wire ram_write_clk_lock_indicator,
   output wire bank0_read_clk_lock_indicator,
   output wire bank1_read_clk_lock_indicator,
   output wire serial_in_clk_lock_indicator,
   output wire frame_double_clk_lock_indicator
);
   // Sequencer states
   localparam ST_IDLE = 2'b00;
   localparam ST_COUNT = 2'b01;
   localparam ST_SAMPLE = 2'b10;
   localparam ST_UPLOAD = 2'b11;
   localparam FIFO_D = 1 << FIFO_AW;
   localparam [16:0] MEM_WORDS = 17'h10000; // Full memory depth

   // Gate width in bits, wide enough for the default count
   localparam GW = 24;
   localparam [GW-1:0] GATE_LAST = GATE_CYC[GW-1:0] - 1'b1;

   reg [1:0] state_q; // Current phase
   reg ext_sel_q; // Route to external SRAM
   reg ddr_q; // Take both converter edges
   reg fwd_q; // Forward to test outputs
   reg [16:0] count_req_q; // Requested sample count
   reg [31:0] freq_q; // Edges seen in last gate
   reg freq_ok_q; // Frequency result valid
   reg ovf_q; // FIFO overflowed in this run
   reg [GW-1:0] gate_q; // Gate window timer
   reg [31:0] edge_cnt_q; // Edges in current gate

   // Synchronisers for pins from outside the clock domain
   reg clk_s1_q, clk_s2_q, clk_s3_q;
   reg [BUS_W-1:0] dat_s1_q, dat_s2_q;
   reg [4:0] lock_s1_q, lock_s2_q;

   // FIFO storage and pointers
   reg [SAMPLE_W-1:0] fifo_mem [0:FIFO_D-1];
   reg [FIFO_AW:0] fifo_wp_q, fifo_rp_q;

   reg [16:0] pushed_q; // Samples taken in
   reg [16:0] stored_q; // Samples written to memory
   reg [ADDR_W-1:0] up_addr_q; // Upload read address
   reg up_pend_q; // Read issued, data next edge, one edge later for external
   reg up_src_q; // Which memory the read came from
   reg [ACT_DIV_W-1:0] act_q; // Activity lamp divider
   reg [3:0] la_cnt_q; // Low-rate decimator

   // Memory ports of the internal store
   reg int_wr_en;
   reg int_rd_en;
   reg [ADDR_W-1:0] mem_waddr;
   wire [SAMPLE_W-1:0] int_rdata;

   // APB decode
   wire apb_wr = psel & penable & pwrite;
   wire apb_rd = psel & ~pwrite;

   // True for any offset this block answers
   function hit;
      input [11:0] a;
      begin
         hit = (a == `ACS_OFF_CTRL) || (a == `ACS_OFF_COUNT) ||
               (a == `ACS_OFF_STATUS) || (a == `ACS_OFF_FREQ);
      end
   endfunction

   // Zero wait states; unmapped offsets answer with an error
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit(paddr);

   // Edge detect on the oversampled converter clock
   wire rise = clk_s2_q & ~clk_s3_q;
   wire fall = ~clk_s2_q & clk_s3_q;
   wire take = rise | (ddr_q & fall);

   // FIFO status
   wire fifo_full = (fifo_wp_q[FIFO_AW] != fifo_rp_q[FIFO_AW]) &&
                    (fifo_wp_q[FIFO_AW-1:0] == fifo_rp_q[FIFO_AW-1:0]);
   wire fifo_empty = (fifo_wp_q == fifo_rp_q);
   wire [16:0] target = (count_req_q == 17'h00000) ? MEM_WORDS : count_req_q;
   wire want = (state_q == ST_SAMPLE) && (pushed_q != target);
   wire push = want & take & ~fifo_full;
   wire pop = (state_q == ST_SAMPLE) & ~fifo_empty;
   wire [SAMPLE_W-1:0] fifo_out = fifo_mem[fifo_rp_q[FIFO_AW-1:0]];
   wire start = apb_wr && (paddr == `ACS_OFF_CTRL) && pwdata[`ACS_CTRL_START];

   // Two-flop synchronisers; the first stage feeds only the second
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_s1_q <= 1'b0;
         clk_s2_q <= 1'b0;
         clk_s3_q <= 1'b0;
         dat_s1_q <= {BUS_W{1'b0}};
         dat_s2_q <= {BUS_W{1'b0}};
         lock_s1_q <= 5'h00;
         lock_s2_q <= 5'h00;
      end else begin
         clk_s1_q <= conv_clk;
         clk_s2_q <= clk_s1_q;
         clk_s3_q <= clk_s2_q; // History for edge detect
         dat_s1_q <= conv_data;
         dat_s2_q <= dat_s1_q; // Same delay as the clock path
         lock_s1_q <= clock_manager_locked;
         lock_s2_q <= lock_s1_q;
      end
   end

   // Control and count registers written by software
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_sel_q <= 1'b0;
         ddr_q <= 1'b0;
         fwd_q <= 1'b0;
         count_req_q <= `ACS_COUNT_RESET;
      end else if (apb_wr && (state_q == ST_IDLE)) begin
         // Settings frozen while a run is active, so a run stays coherent
         if (paddr == `ACS_OFF_CTRL) begin
            ext_sel_q <= pwdata[`ACS_CTRL_EXT_SEL];
            ddr_q <= pwdata[`ACS_CTRL_DDR];
            fwd_q <= pwdata[`ACS_CTRL_FWD];
         end else if (paddr == `ACS_OFF_COUNT) begin
            count_req_q <= pwdata[16:0];
         end
      end
   end

   // Read mux, registered so prdata is a flop output
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (apb_rd && !penable) begin
         if (paddr == `ACS_OFF_CTRL) begin
            prdata <= {28'h0000000, fwd_q, ddr_q, ext_sel_q, 1'b0};
         end else if (paddr == `ACS_OFF_COUNT) begin
            prdata <= {15'h0000, count_req_q};
         end else if (paddr == `ACS_OFF_STATUS) begin
            prdata <= {19'h00000, lock_s2_q, 3'h0, freq_ok_q, ovf_q,
                       (state_q == ST_IDLE), state_q};
         end else if (paddr == `ACS_OFF_FREQ) begin
            prdata <= freq_q;
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end

   // Phase sequencer; a start outside idle is ignored
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (start) begin
                  state_q <= ST_COUNT;
               end
            end
            ST_COUNT: begin
               if (gate_q == GATE_LAST) begin
                  state_q <= ST_SAMPLE;
               end
            end
            ST_SAMPLE: begin
               // Leave only when all samples reached memory
               if ((stored_q == target) && fifo_empty) begin
                  state_q <= ST_UPLOAD;
               end
            end
            default: begin
               if (usb_valid && usb_ready && (up_addr_q == target[ADDR_W-1:0] - 1'b1)) begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Frequency counter: edges of the converter clock in a fixed gate
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_q <= {GW{1'b0}};
         edge_cnt_q <= 32'h00000000;
         freq_q <= 32'h00000000;
         freq_ok_q <= 1'b0;
      end else if (state_q == ST_COUNT) begin
         gate_q <= gate_q + 1'b1;
         if (gate_q == GATE_LAST) begin
            // Last edge of the window still counts
            freq_q <= edge_cnt_q + {31'h00000000, rise};
            freq_ok_q <= 1'b1;
         end else begin
            edge_cnt_q <= edge_cnt_q + {31'h00000000, rise};
         end
      end else begin
         gate_q <= {GW{1'b0}};
         edge_cnt_q <= 32'h00000000;
         // A refused start in mid-run must not hide the last result
         if (start && (state_q == ST_IDLE)) begin
            freq_ok_q <= 1'b0;
         end
      end
   end

   // FIFO write side, fed at converter edges
   always @(posedge pclk) begin
      if (push) begin
         fifo_mem[fifo_wp_q[FIFO_AW-1:0]] <= dat_s2_q[SAMPLE_W-1:0];
      end
   end

   // FIFO pointers, counters and the overflow flag
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_wp_q <= {(FIFO_AW+1){1'b0}};
         fifo_rp_q <= {(FIFO_AW+1){1'b0}};
         pushed_q <= 17'h00000;
         stored_q <= 17'h00000;
         ovf_q <= 1'b0;
      end else if (start && (state_q == ST_IDLE)) begin
         fifo_wp_q <= {(FIFO_AW+1){1'b0}};
         fifo_rp_q <= {(FIFO_AW+1){1'b0}};
         pushed_q <= 17'h00000;
         stored_q <= 17'h00000;
         ovf_q <= 1'b0;
      end else begin
         if (push) begin
            fifo_wp_q <= fifo_wp_q + 1'b1;
            pushed_q <= pushed_q + 1'b1;
         end
         if (pop) begin
            fifo_rp_q <= fifo_rp_q + 1'b1;
            stored_q <= stored_q + 1'b1;
         end
         if (want && take && fifo_full) begin
            ovf_q <= 1'b1; // Sample lost; cannot happen while memory keeps pace
         end
      end
   end

   // Memory write routing after the FIFO
   always @* begin
      mem_waddr = stored_q[ADDR_W-1:0];
      int_wr_en = pop & ~ext_sel_q;
   end

   // External SRAM port, registered outputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_wr_en <= 1'b0;
         ext_rd_en <= 1'b0;
         ext_addr <= {ADDR_W{1'b0}};
         ext_wdata <= {SAMPLE_W{1'b0}};
      end else begin
         ext_wr_en <= pop & ext_sel_q;
         ext_rd_en <= int_rd_en & ext_sel_q;
         if (pop) begin
            ext_addr <= mem_waddr;
            ext_wdata <= fifo_out;
         end else if (int_rd_en) begin
            ext_addr <= up_addr_q;
         end
      end
   end

   // Internal memory, one read issue per uploaded word
   acs_sample_ram #(
      .AW(ADDR_W),
      .DW(SAMPLE_W)
   ) u_ram (
      .clk(pclk),
      .wr_en(int_wr_en),
      .wr_addr(mem_waddr),
      .wr_data(fifo_out),
      .rd_en(int_rd_en & ~ext_sel_q),
      .rd_addr(up_addr_q),
      .rd_data(int_rdata)
   );

   // Issue a read when no word is pending or on offer
   always @* begin
      int_rd_en = (state_q == ST_UPLOAD) & ~up_pend_q & ~usb_valid;
   end

   // Upload engine: read, present, wait for the USB side to take it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_addr_q <= {ADDR_W{1'b0}};
         up_pend_q <= 1'b0;
         up_src_q <= 1'b0;
         usb_valid <= 1'b0;
         usb_data <= {SAMPLE_W{1'b0}};
      end else if (state_q != ST_UPLOAD) begin
         up_addr_q <= {ADDR_W{1'b0}};
         up_pend_q <= 1'b0;
         usb_valid <= 1'b0;
      end else if (int_rd_en) begin
         up_pend_q <= 1'b1;
         up_src_q <= ext_sel_q;
      end else if (up_pend_q) begin
         // External reads need one more edge: address went out registered
         if (!up_src_q || !ext_rd_en) begin
            up_pend_q <= 1'b0;
            usb_valid <= 1'b1;
            usb_data <= up_src_q ? ext_rdata : int_rdata;
         end
      end else if (usb_valid && usb_ready) begin
         usb_valid <= 1'b0;
         up_addr_q <= up_addr_q + 1'b1;
      end
   end

   // Forwarding to test outputs: every sample to the probe, 1 in N to the header
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         probe_data <= {SAMPLE_W{1'b0}};
         probe_valid <= 1'b0;
         la_data <= {SAMPLE_W{1'b0}};
         la_cnt_q <= 4'h0;
      end else begin
         probe_valid <= fwd_q & take;
         if (fwd_q && take) begin
            probe_data <= dat_s2_q[SAMPLE_W-1:0];
            if (la_cnt_q == `ACS_LA_DIV - 1) begin
               la_cnt_q <= 4'h0;
               la_data <= dat_s2_q[SAMPLE_W-1:0];
            end else begin
               la_cnt_q <= la_cnt_q + 1'b1;
            end
         end
      end
   end

   // Activity lamp: divided converter edges so the flashing is visible
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_q <= {ACT_DIV_W{1'b0}};
      end else if (rise) begin
         act_q <= act_q + 1'b1;
      end
   end

   // Lamps follow phase; a loaded, reset design shows idle at once
   assign idle_indicator = (state_q == ST_IDLE);
   assign sample_indicator = (state_q == ST_SAMPLE);
   assign upload_indicator = (state_q == ST_COUNT) | (state_q == ST_UPLOAD);
   assign conv_clock_activity_indicator = act_q[ACT_DIV_W-1];
   assign ram_write_clk_lock_indicator = lock_s2_q[0];
   assign bank0_read_clk_lock_indicator = lock_s2_q[1];
   assign bank1_read_clk_lock_indicator = lock_s2_q[2];
   assign serial_in_clk_lock_indicator = lock_s2_q[3];
   assign frame_double_clk_lock_indicator = lock_s2_q[4];
endmodule // acs_capture

// [hdl/acs_regs.vh]
/*
 Register offsets, field positions, reset values and timing figures of the
 capture sequencer. Assumes a 32-bit APB with byte addresses in paddr[11:0].
*/
`ifndef ACS_REGS_VH
`define ACS_REGS_VH
// Byte offsets, one aligned word each
`define ACS_OFF_CTRL 12'h000
`define ACS_OFF_COUNT 12'h004
`define ACS_OFF_STATUS 12'h008
`define ACS_OFF_FREQ 12'h00C
`define ACS_OFF_UNUSED_MASK 12'h003
// Control register bits
`define ACS_CTRL_START 0
`define ACS_CTRL_EXT_SEL 1
`define ACS_CTRL_DDR 2
`define ACS_CTRL_FWD 3
`define ACS_CTRL_RESET 4'h0
// Status register fields
`define ACS_STAT_STATE_LO 0
`define ACS_STAT_STATE_HI 1
`define ACS_STAT_IDLE 2
`define ACS_STAT_OVF 3
`define ACS_STAT_FREQ_OK 4
`define ACS_STAT_LOCK_LO 8
`define ACS_STAT_LOCK_HI 12
// Requested sample count after reset, 0 means whole memory
`define ACS_COUNT_RESET 17'h00000
// Timing: system clock rate and frequency-count gate window
`define ACS_CLK_KHZ 50000
`define ACS_GATE_MS 100
// Low-rate header gets every Nth sample
`define ACS_LA_DIV 8
`endif

// [hdl/acs_sample_ram.v]
/*
 Internal sample memory: one write port, one read port, registered read data.
 Assumes both ports run on the system clock; read data appear one edge after
 rd_en.
*/
`timescale 1ns/1ps
module acs_sample_ram #(
   parameter AW = 16,
   parameter DW = 16
) (
   input wire clk,
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [DW-1:0] wr_data,
   input wire rd_en,
   input wire [AW-1:0] rd_addr,
   output reg [DW-1:0] rd_data
);
   // Storage, left without reset so it maps onto block memory
   reg [DW-1:0] mem [0:(1<<AW)-1];

   // Write port
   always @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Registered read port
   always @(posedge clk) begin
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule // acs_sample_ram

// [verif/acs_capture_properties.sv]
/* Port checker for the capture sequencer.
 Assumes one pclk domain with presetn async active low. */
`timescale 1ns/1ps
`include "acs_regs.vh"
module acs_capture_properties #(
   parameter SAMPLE_W = 16
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire ext_wr_en,
   input wire [SAMPLE_W-1:0] usb_data,
   input wire usb_valid,
   input wire usb_ready,
   input wire [4:0] clock_manager_locked,
   input wire upload_indicator,
   input wire sample_indicator,
   input wire idle_indicator,
   input wire ram_write_clk_lock_indicator,
   input wire bank0_read_clk_lock_indicator,
   input wire bank1_read_clk_lock_indicator,
   input wire serial_in_clk_lock_indicator,
   input wire frame_double_clk_lock_indicator
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Lamps gathered in input order
   wire [4:0] lamps = {frame_double_clk_lock_indicator, serial_in_clk_lock_indicator,
      bank1_read_clk_lock_indicator, bank0_read_clk_lock_indicator, ram_write_clk_lock_indicator};
   // Cycles since reset; lock synchronisers hold reset values at first
   reg [1:0] rc_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rc_q <= 2'h0;
      end else if (rc_q != 2'h3) begin
         rc_q <= rc_q + 2'h1;
      end
   end
   a_idle_alone: assert property (idle_indicator |-> !(sample_indicator || upload_indicator))
      else $error("idle lamp lit beside an activity lamp");
   a_start_count: assert property (psel && penable && pwrite && paddr == `ACS_OFF_CTRL && pwdata[0]
      && idle_indicator |=> upload_indicator && !idle_indicator)
      else $error("start did not enter the count phase");
   a_sample_order: assert property ($rose(sample_indicator) |-> $past(upload_indicator))
      else $error("sampling began without a count phase");
   a_upload_src: assert property ($rose(upload_indicator) |-> $past(idle_indicator) || $past(sample_indicator))
      else $error("upload began out of order");
   a_usb_hold: assert property (usb_valid && !usb_ready |=> usb_valid && $stable(usb_data))
      else $error("usb word dropped before taken");
   a_usb_phase: assert property (usb_valid |-> upload_indicator)
      else $error("usb word outside upload");
   a_lock_follow: assert property (rc_q == 2'h3 && $stable(clock_manager_locked) [*3]
      |-> lamps == clock_manager_locked)
      else $error("lock lamps do not follow the lock inputs");
   a_ext_write: assert property (ext_wr_en |-> sample_indicator || $past(sample_indicator))
      else $error("external write outside sampling");
   c_sample: cover property ($rose(sample_indicator));
   c_take: cover property (usb_valid && usb_ready);
   c_done: cover property ($fell(upload_indicator) ##1 idle_indicator);
endmodule // acs_capture_properties

// [verif/acs_adc_model.sv]
/* Converter board stand-in: source-synchronous clock and counting data.
 Assumes run frames an acquisition; clock rests low outside it. */
`timescale 1ns/1ps
module acs_adc_model (
   input wire run,
   input wire ddr,
   output reg conv_clk,
   output reg [35:0] conv_data
);
   // Data moves mid-way between edges so each used edge sees it settled
   initial begin
      conv_clk = 1'b0;
      conv_data = 36'h000000000;
      forever begin
         if (run) begin
            conv_clk = 1'b1;
            #40;
            if (ddr) begin
               conv_data = conv_data + 36'h000000001;
            end
            #40;
            conv_clk = 1'b0;
            #40;
            conv_data = conv_data + 36'h000000001;
            #40;
         end else begin
            #80;
            conv_data = ~conv_data; // Idle lines carry no stale value
         end
      end
   end
endmodule // acs_adc_model

// [verif/testbench.sv]
/* Self-checking bench for the capture sequencer.
 Assumes acs_capture, the converter model and the port checker. */
`timescale 1ns/1ps
`include "acs_regs.vh"
module testbench;
   localparam GATE = 200; // Short count gate
   localparam EDGES = GATE * 20 / 160; // Converter edges per gate
   reg pclk, presetn, psel, penable, pwrite, usb_ready, run, ddr, err, act_prev;
   reg [11:0] paddr;
   reg [31:0] pwdata, rd, rnd;
   reg [15:0] ext_rdata, pv_last;
   reg [4:0] locks;
   reg [15:0] mem [0:255]; // External SRAM stand-in
   reg [15:0] q [$]; // Words taken on the usb side
   wire [31:0] prdata;
   wire pready, pslverr, conv_clk, ext_wr_en, ext_rd_en, usb_valid, probe_valid, up_i, smp_i, idl_i, act_i;
   wire [35:0] conv_data;
   wire [15:0] ext_addr, ext_wdata, usb_data, la_data, probe_data;
   wire [4:0] lk_i;
   integer n_fail, total_checks, seed, n_wr, n_pv, n_act, n_all, i, m, n, k;
   // Status word expected for the idle phase
   function [31:0] exp_status(input [4:0] lk, input fv);
      exp_status = {19'h00000, lk, 3'h0, fv, 1'b0, 1'b1, 2'h0};
   endfunction
   acs_capture #(.ACT_DIV_W(3), .GATE_CYC(GATE)) u_acs_capture (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .conv_clk(conv_clk), .conv_data(conv_data), .ext_wr_en(ext_wr_en),
      .ext_rd_en(ext_rd_en), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
      .usb_data(usb_data), .usb_valid(usb_valid), .usb_ready(usb_ready), .la_data(la_data),
      .probe_data(probe_data), .probe_valid(probe_valid), .clock_manager_locked(locks),
      .upload_indicator(up_i), .sample_indicator(smp_i), .idle_indicator(idl_i),
      .conv_clock_activity_indicator(act_i), .ram_write_clk_lock_indicator(lk_i[0]),
      .bank0_read_clk_lock_indicator(lk_i[1]), .bank1_read_clk_lock_indicator(lk_i[2]),
      .serial_in_clk_lock_indicator(lk_i[3]), .frame_double_clk_lock_indicator(lk_i[4]));
   acs_adc_model u_acs_adc_model (.run(run), .ddr(ddr), .conv_clk(conv_clk), .conv_data(conv_data));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // SRAM answers one edge after a read; usb side stalls at random
   always @(posedge pclk) begin
      rnd = $random(seed);
      usb_ready <= rnd[0];
      if (ext_wr_en) begin
         mem[ext_addr[7:0]] <= ext_wdata;
         n_wr <= n_wr + 1;
      end
      ext_rdata <= ext_rd_en ? mem[ext_addr[7:0]] : ~ext_rdata;
      if (usb_valid && usb_ready) begin
         q.push_back(usb_data);
      end
      if (probe_valid) begin
         if (n_pv != 0) chk("probe_seq", probe_data, {16'h0000, pv_last + 16'h0001});
         if (n_all % `ACS_LA_DIV == `ACS_LA_DIV - 1) chk("la", la_data, probe_data);
         pv_last <= probe_data;
         n_pv <= n_pv + 1;
         n_all <= n_all + 1;
      end
      if (act_i !== act_prev) begin
         n_act <= n_act + 1;
      end
      act_prev <= act_i;
   end
   task chk(input string name, input [31:0] seen, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("[ERR] %0s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   task conclude;
      begin
         $display("checks %0d mismatches %0d", total_checks, n_fail);
         if (n_fail == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // One APB transfer; read data and error taken at the ready edge
   task apb(input [11:0] a, input w, input [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         k = 0;
         do begin
            @(posedge pclk);
            k = k + 1;
         end while (pready !== 1'b1 && k < 50);
         chk("apb_wait", k < 50, 1);
         if (k >= 50) conclude;
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   initial begin
      seed = 13;
      n_fail = 0;
      total_checks = 0;
      {psel, penable, pwrite, usb_ready, run, ddr, act_prev} = 7'h00;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      ext_rdata = 16'h0000;
      pv_last = 16'h0000;
      n_all = 0;
      {n_wr, n_pv, n_act} = 0;
      locks = $random(seed);
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("idle", idl_i, 1);
      apb(`ACS_OFF_CTRL, 0, 0);
      chk("ctrl", rd, 0);
      apb(`ACS_OFF_COUNT, 0, 0);
      chk("count", rd, 0);
      apb(`ACS_OFF_STATUS, 0, 0);
      chk("status", rd, exp_status(locks, 1'b0));
      chk("lamps", lk_i, locks);
      apb(12'h010, 0, 0);
      chk("unmapped", {err, rd[30:0]}, 32'h80000000);
      $display("reset test done");
      // Every destination and edge mode; bit1 external, bit2 both edges
      for (m = 0; m < 4; m = m + 1) begin
         n = 4 + ($random(seed) & 7);
         ddr <= m[1];
         locks <= $random(seed);
         apb(`ACS_OFF_COUNT, 1, n);
         q.delete();
         {n_wr, n_pv, n_act} = 0;
         chk("idle_first", idl_i, 1);
         run <= 1'b1;
         apb(`ACS_OFF_CTRL, 1, (m << 1) | 9);
         apb(`ACS_OFF_COUNT, 1, 3); // Refused while busy
         k = 0;
         while (idl_i !== 1'b1 && k < 5000) begin
            @(posedge pclk);
            k = k + 1;
         end
         chk("run_wait", k < 5000, 1);
         if (k >= 5000) conclude;
         run <= 1'b0;
         chk("words", q.size(), n);
         for (i = 1; i < q.size(); i = i + 1)
            chk("order", q[i], {16'h0000, q[0] + i[15:0]});
         chk("ext_writes", n_wr, m[0] ? n : 0);
         chk("probe", n_pv != 0, 1);
         chk("activity", n_act >= 4, 1);
         chk("lamps_run", lk_i, locks);
         apb(`ACS_OFF_COUNT, 0, 0);
         chk("count_kept", rd, n);
         apb(`ACS_OFF_STATUS, 0, 0);
         chk("status_end", rd, exp_status(locks, 1'b1));
         apb(`ACS_OFF_FREQ, 0, 0);
         chk("freq", rd + 1 >= EDGES && rd <= EDGES + 1, 1);
         $display("capture test %0d done", m);
      end
      conclude;
   end
endmodule // testbench
bind acs_capture acs_capture_properties #(.SAMPLE_W(SAMPLE_W)) u_acs_capture_properties (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .ext_wr_en(ext_wr_en), .usb_data(usb_data), .usb_valid(usb_valid), .usb_ready(usb_ready),
   .clock_manager_locked(clock_manager_locked), .upload_indicator(upload_indicator),
   .sample_indicator(sample_indicator), .idle_indicator(idle_indicator),
   .ram_write_clk_lock_indicator(ram_write_clk_lock_indicator),
   .bank0_read_clk_lock_indicator(bank0_read_clk_lock_indicator),
   .bank1_read_clk_lock_indicator(bank1_read_clk_lock_indicator),
   .serial_in_clk_lock_indicator(serial_in_clk_lock_indicator),
   .frame_double_clk_lock_indicator(frame_double_clk_lock_indicator));
